// [design/cmfs_pkg.sv]
// Operation
// - Primary mode-select pin low selects register-driven extended mode, high selects simple mode.
// - Primary floating, qualifier floating/high: range strap at mid selects extended mode.
// - Rate choice: edge/rate strap in simple mode, register 1h bit 10 extended.
// - DDR clock phase is 0 degrees in simple mode, register 1h bit 11 extended.
// - SDR edge: strap high rising, low falling; extended uses register 1h bit 8.
// - LVDS swing: strap high normal, low reduced; extended uses register 1h bit 9.
// - Calibration delay: strap low short, high long; extended mode always short.
// - Simple: one range strap for both channels; extended: 3h/Bh bits 15:7.
// - No offset in simple mode; extended takes 2h/Ah bits 15:7.
// - Interleave: delay strap at mid in simple mode; extended uses 9h bit 13.
// - Interleave input: I only in simple mode; extended may pick I or Q.
// - Test pattern only in extended mode when 9h bit 15 is one.
// - Trim-disable field makes the data clock run always, extended mode only.
// - Extended DDR: 1h bit 8 one gives non-demux, zero gives 1:2 demux.
// - Extended only: 1h bit 13 zero turns out-of-range pair into second clock.
// - Extended only: sample phase from Fh bits 15:7 and Eh bits 15:8.
// - Power-on reset loads extended defaults: DDR 0 deg, normal, 1:2, no adjust.
// - Simple mode: edge/rate strap floating or at mid selects DDR clocking.
// - Configuration registers have no effect while simple mode is active.
// - Serial register interface accepts writes only in extended mode.
package cmfs_pkg;
	// ====================================================================
	// Serial frame
	localparam int          FRAME_BITS       = 32;
	localparam logic [4:0]  FRAME_LAST       = 5'h1F;
	localparam logic [11:0] HDR_PATTERN      = 12'h001;
	// ====================================================================
	// Register addresses
	localparam logic [3:0]  ADDR_OUTPUT_CFG  = 4'h1;
	localparam logic [3:0]  ADDR_I_OFFSET    = 4'h2;
	localparam logic [3:0]  ADDR_I_RANGE     = 4'h3;
	localparam logic [3:0]  ADDR_EXT_CFG     = 4'h9;
	localparam logic [3:0]  ADDR_Q_OFFSET    = 4'hA;
	localparam logic [3:0]  ADDR_Q_RANGE     = 4'hB;
	localparam logic [3:0]  ADDR_PHASE_FINE  = 4'hE;
	localparam logic [3:0]  ADDR_PHASE_CRS   = 4'hF;
	// ====================================================================
	// Field positions
	localparam int          CFG_SECOND_CLK   = 13;
	localparam int          CFG_PHASE        = 11;
	localparam int          CFG_RATE_N       = 10;
	localparam int          CFG_SWING        = 9;
	localparam int          CFG_EDGE_DEMUX   = 8;
	localparam int          EXT_TEST_PAT     = 15;
	localparam int          EXT_TRIM_OFF     = 14;
	localparam int          EXT_INTERLEAVE   = 13;
	localparam int          EXT_DES_Q_SEL    = 12;
	localparam int          FIELD_MSB        = 15;
	localparam int          FIELD_LSB        = 7;
	localparam int          FINE_LSB         = 8;
	// ====================================================================
	// Power-on values and fixed codes
	localparam logic [15:0] RST_OUTPUT_CFG   = 16'hB2FF;
	localparam logic [15:0] RST_OFFSET       = 16'h0000;
	localparam logic [15:0] RST_RANGE        = 16'h8000;
	localparam logic [15:0] RST_EXT_CFG      = 16'h0000;
	localparam logic [15:0] RST_PHASE        = 16'h0000;
	localparam logic [8:0]  RANGE_NORMAL     = 9'h100;
	localparam logic [8:0]  RANGE_REDUCED    = 9'h000;
	localparam logic [8:0]  OFFSET_NONE      = 9'h000;
	localparam logic [1:0]  SETTLE_CYCLES    = 2'h3;

	typedef enum logic {CMFS_SETTLE, CMFS_HELD} cmfs_lock_t;

	// Pad comparators see neither level: pin floats or sits at mid-supply
	function automatic logic cmfs_is_mid(input logic hi, input logic lo);
		return !hi && !lo;
	endfunction : cmfs_is_mid
endpackage : cmfs_pkg

// [design/cmfs_wr_if.sv]
// Decoded register write from the serial engine
interface cmfs_wr_if;
	logic        accept_en;
	logic        wr_valid;
	logic [3:0]  wr_addr;
	logic [15:0] wr_data;

	modport ser
	(
		input  accept_en,
		output wr_valid,
		output wr_addr,
		output wr_data
	);
	modport regs
	(
		output accept_en,
		input  wr_valid,
		input  wr_addr,
		input  wr_data
	);
endinterface : cmfs_wr_if

// [design/cmfs_serial.sv]
module cmfs_serial
	import cmfs_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic sclk,
	input  wire logic sdata,
	input  wire logic scs_n,
	cmfs_wr_if.ser    wr
);
	// ====================================================================
	// Pin synchronisers; third sclk stage only feeds the edge detector
	logic [2:0]  s1_q;
	logic [2:0]  s2_q;
	logic        sclk_s3_q;
	logic [31:0] shift_q;
	logic [4:0]  cnt_q;
	logic        wr_valid_q;
	logic [3:0]  wr_addr_q;
	logic [15:0] wr_data_q;
	wire         sclk_rise = s2_q[0] && !sclk_s3_q;
	wire         selected  = !s2_q[2] && wr.accept_en;
	wire  [31:0] shift_d   = {shift_q[30:0], s2_q[1]};
	wire         frame_end = selected && sclk_rise && (cnt_q == FRAME_LAST);
	wire         hdr_ok    = shift_d[31:20] == HDR_PATTERN;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			s1_q      <= 3'h4;
			s2_q      <= 3'h4;
			sclk_s3_q <= 1'b0;
		end else begin
			s1_q      <= {scs_n, sdata, sclk};
			s2_q      <= s1_q;
			sclk_s3_q <= s2_q[0];
		end
	end

	// Count wraps at 32 so frames may follow without lifting select
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			shift_q <= 32'h0;
			cnt_q   <= 5'h0;
		end else if (!selected) begin
			cnt_q   <= 5'h0;
		end else if (sclk_rise) begin
			shift_q <= shift_d;
			cnt_q   <= cnt_q + 5'h1;
		end
	end

	// Bad header drops the frame silently; no status path exists
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			wr_valid_q <= 1'b0;
			wr_addr_q  <= 4'h0;
			wr_data_q  <= 16'h0;
		end else begin
			wr_valid_q <= frame_end && hdr_ok;
			if (frame_end) begin
				wr_addr_q <= shift_d[19:16];
				wr_data_q <= shift_d[15:0];
			end
		end
	end

	assign wr.wr_valid = wr_valid_q;
	assign wr.wr_addr  = wr_addr_q;
	assign wr.wr_data  = wr_data_q;

	// ====================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_no_write_simple: assert property (!wr.accept_en |=> !wr_valid_q)
		else $error("write issued outside extended mode");
endmodule : cmfs_serial

// [design/cmfs_top.sv]
module cmfs_top
	import cmfs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       mode_sel_n_hi,
	input  wire logic       mode_sel_n_lo,
	input  wire logic       mode_qual_hi,
	input  wire logic       mode_qual_lo,
	input  wire logic       range_strap_hi,
	input  wire logic       range_strap_lo,
	input  wire logic       rate_edge_hi,
	input  wire logic       rate_edge_lo,
	input  wire logic       delay_strap_hi,
	input  wire logic       delay_strap_lo,
	input  wire logic       swing_strap,
	input  wire logic       sclk,
	input  wire logic       sdata,
	input  wire logic       scs_n,
	output logic            ext_mode,
	output logic            double_rate_select_n,
	output logic            ddr_clock_phase_sel,
	output logic            sdr_edge_demux_sel,
	output logic            output_swing_sel,
	output logic            cal_delay_long,
	output logic [8:0]      range_i,
	output logic [8:0]      range_q,
	output logic [8:0]      offset_i,
	output logic [8:0]      offset_q,
	output logic            interleave_enable,
	output logic            interleave_q_input,
	output logic            test_pattern_enable,
	output logic            trim_off_clock_always,
	output logic            second_clock_n,
	output logic [8:0]      phase_coarse,
	output logic [7:0]      phase_fine
);
	// ====================================================================
	// Strap synchronisers
	logic [10:0] strap_s1_q;
	logic [10:0] strap_s2_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			strap_s1_q <= 11'h0;
			strap_s2_q <= 11'h0;
		end else begin
			strap_s1_q <= {swing_strap, delay_strap_hi, delay_strap_lo, rate_edge_hi,
			               rate_edge_lo, range_strap_hi, range_strap_lo, mode_qual_hi,
			               mode_qual_lo, mode_sel_n_hi, mode_sel_n_lo};
			strap_s2_q <= strap_s1_q;
		end
	end

	// Named views of the synchronised straps
	wire sel_hi    = strap_s2_q[1];
	wire sel_lo    = strap_s2_q[0];
	wire qual_hi   = strap_s2_q[3];
	wire qual_lo   = strap_s2_q[2];
	wire range_hi  = strap_s2_q[5];
	wire range_lo  = strap_s2_q[4];
	wire rate_hi   = strap_s2_q[7];
	wire rate_lo   = strap_s2_q[6];
	wire delay_hi  = strap_s2_q[9];
	wire delay_lo  = strap_s2_q[8];
	wire swing_s   = strap_s2_q[10];

	// ====================================================================
	// Control-mode resolution
	wire sel_mid   = cmfs_is_mid(sel_hi, sel_lo);
	wire qual_ok   = cmfs_is_mid(qual_hi, qual_lo) || qual_hi;
	wire range_mid = cmfs_is_mid(range_hi, range_lo);
	wire ext_pick  = sel_lo || (sel_mid && qual_ok && range_mid);

	cmfs_lock_t  lock_q;
	cmfs_lock_t  lock_d;
	logic [1:0]  settle_q;
	logic        ext_q;

	// Mode is sampled on each of the four settle cycles, the last sample kept, then frozen;
	// a board that switches it later gets no reaction by design
	always_comb
	begin
		case (lock_q)
			CMFS_SETTLE: lock_d = (settle_q == SETTLE_CYCLES) ? CMFS_HELD : CMFS_SETTLE;
			CMFS_HELD:   lock_d = CMFS_HELD;
			default:     lock_d = CMFS_SETTLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			lock_q   <= CMFS_SETTLE;
			settle_q <= 2'h0;
			ext_q    <= 1'b0;
		end else begin
			lock_q <= lock_d;
			if (lock_q == CMFS_SETTLE) begin
				settle_q <= settle_q + 2'h1;
				ext_q    <= ext_pick;
			end
		end
	end

	wire ext_live = (lock_q == CMFS_HELD) && ext_q;

	// ====================================================================
	// Serial engine and register file
	cmfs_wr_if wr_bus ();

	assign wr_bus.accept_en = ext_live;

	cmfs_serial u_serial
	(
		.clk   (clk),
		.rstn  (rstn),
		.sclk  (sclk),
		.sdata (sdata),
		.scs_n (scs_n),
		.wr    (wr_bus.ser)
	);

	logic [15:0] output_config_q;
	logic [15:0] i_channel_offset_q;
	logic [15:0] i_channel_range_q;
	logic [15:0] extended_config_q;
	logic [15:0] q_channel_offset_q;
	logic [15:0] q_channel_range_q;
	logic [15:0] phase_fine_adjust_q;
	logic [15:0] phase_coarse_adjust_q;

	// Address decode; unmapped and reserved addresses are dropped
	wire hit_cfg   = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_OUTPUT_CFG);
	wire hit_ioff  = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_I_OFFSET);
	wire hit_irng  = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_I_RANGE);
	wire hit_ext   = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_EXT_CFG);
	wire hit_qoff  = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_Q_OFFSET);
	wire hit_qrng  = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_Q_RANGE);
	wire hit_fine  = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_PHASE_FINE);
	wire hit_crs   = wr_bus.wr_valid && (wr_bus.wr_addr == ADDR_PHASE_CRS);

	// Power-on values of the extended settings
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			output_config_q       <= RST_OUTPUT_CFG;
			i_channel_offset_q    <= RST_OFFSET;
			i_channel_range_q     <= RST_RANGE;
			extended_config_q     <= RST_EXT_CFG;
			q_channel_offset_q    <= RST_OFFSET;
			q_channel_range_q     <= RST_RANGE;
			phase_fine_adjust_q   <= RST_PHASE;
			phase_coarse_adjust_q <= RST_PHASE;
		end else begin
			if (hit_cfg)  output_config_q       <= wr_bus.wr_data;
			if (hit_ioff) i_channel_offset_q    <= wr_bus.wr_data;
			if (hit_irng) i_channel_range_q     <= wr_bus.wr_data;
			if (hit_ext)  extended_config_q     <= wr_bus.wr_data;
			if (hit_qoff) q_channel_offset_q    <= wr_bus.wr_data;
			if (hit_qrng) q_channel_range_q     <= wr_bus.wr_data;
			if (hit_fine) phase_fine_adjust_q   <= wr_bus.wr_data;
			if (hit_crs)  phase_coarse_adjust_q <= wr_bus.wr_data;
		end
	end

	// ====================================================================
	// Strap-side values
	wire rate_mid   = cmfs_is_mid(rate_hi, rate_lo);
	wire delay_mid  = cmfs_is_mid(delay_hi, delay_lo);
	wire s_rate_n   = !rate_mid;
	wire s_edge     = rate_hi;
	wire s_delay    = delay_hi;
	wire [8:0] s_rng = range_hi ? RANGE_NORMAL : RANGE_REDUCED;

	// Register-side fields
	wire r_rate_n   = output_config_q[CFG_RATE_N];
	wire r_phase    = output_config_q[CFG_PHASE];
	wire r_edge     = output_config_q[CFG_EDGE_DEMUX];
	wire r_swing    = output_config_q[CFG_SWING];
	wire r_second_n = output_config_q[CFG_SECOND_CLK];
	wire r_tp       = extended_config_q[EXT_TEST_PAT];
	wire r_trim     = extended_config_q[EXT_TRIM_OFF];
	wire r_des      = extended_config_q[EXT_INTERLEAVE];
	wire r_des_q    = extended_config_q[EXT_DES_Q_SEL];

	// One mux per control; registers are invisible in simple mode
	wire       m_rate_n  = ext_live ? r_rate_n : s_rate_n;
	wire       m_phase   = ext_live ? r_phase : 1'b0;
	wire       m_edge    = ext_live ? r_edge : s_edge;
	wire       m_swing   = ext_live ? r_swing : swing_s;
	wire       m_delay   = ext_live ? 1'b0 : s_delay;
	wire [8:0] m_rng_i   = ext_live ? i_channel_range_q[FIELD_MSB:FIELD_LSB] : s_rng;
	wire [8:0] m_rng_q   = ext_live ? q_channel_range_q[FIELD_MSB:FIELD_LSB] : s_rng;
	wire [8:0] m_off_i   = ext_live ? i_channel_offset_q[FIELD_MSB:FIELD_LSB] : OFFSET_NONE;
	wire [8:0] m_off_q   = ext_live ? q_channel_offset_q[FIELD_MSB:FIELD_LSB] : OFFSET_NONE;
	wire       m_des     = ext_live ? r_des : delay_mid;
	wire       m_des_q   = ext_live && r_des_q;
	wire       m_tp      = ext_live && r_tp;
	wire       m_trim    = ext_live && r_trim;
	wire       m_second  = ext_live ? r_second_n : 1'b1;
	wire [8:0] m_crs     = ext_live ? phase_coarse_adjust_q[FIELD_MSB:FIELD_LSB] : 9'h000;
	wire [7:0] m_fine    = ext_live ? phase_fine_adjust_q[FIELD_MSB:FINE_LSB] : 8'h00;

	// ====================================================================
	// Output flops; until the mode is held these show simple-mode values
	logic       rate_n_q;
	logic       phase_q;
	logic       edge_q;
	logic       swing_q;
	logic       delay_q;
	logic [8:0] rng_i_q;
	logic [8:0] rng_q_q;
	logic [8:0] off_i_q;
	logic [8:0] off_q_q;
	logic       des_q;
	logic       des_qsel_q;
	logic       tp_q;
	logic       trim_q;
	logic       second_q;
	logic [8:0] crs_q;
	logic [7:0] fine_q;
	logic       ext_out_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			{rate_n_q, phase_q, edge_q, swing_q, delay_q} <= 5'h0;
			{rng_i_q, rng_q_q, off_i_q, off_q_q}          <= 36'h0;
			{des_q, des_qsel_q, tp_q, trim_q, second_q}   <= 5'h01;
			{crs_q, fine_q, ext_out_q}                    <= 18'h0;
		end else begin
			rate_n_q   <= m_rate_n;
			phase_q    <= m_phase;
			edge_q     <= m_edge;
			swing_q    <= m_swing;
			delay_q    <= m_delay;
			rng_i_q    <= m_rng_i;
			rng_q_q    <= m_rng_q;
			off_i_q    <= m_off_i;
			off_q_q    <= m_off_q;
			des_q      <= m_des;
			des_qsel_q <= m_des_q;
			tp_q       <= m_tp;
			trim_q     <= m_trim;
			second_q   <= m_second;
			crs_q      <= m_crs;
			fine_q     <= m_fine;
			ext_out_q  <= ext_live;
		end
	end

	assign ext_mode              = ext_out_q;
	assign double_rate_select_n  = rate_n_q;
	assign ddr_clock_phase_sel   = phase_q;
	assign sdr_edge_demux_sel    = edge_q;
	assign output_swing_sel      = swing_q;
	assign cal_delay_long        = delay_q;
	assign range_i               = rng_i_q;
	assign range_q               = rng_q_q;
	assign offset_i              = off_i_q;
	assign offset_q              = off_q_q;
	assign interleave_enable     = des_q;
	assign interleave_q_input    = des_qsel_q;
	assign test_pattern_enable   = tp_q;
	assign trim_off_clock_always = trim_q;
	assign second_clock_n        = second_q;
	assign phase_coarse          = crs_q;
	assign phase_fine            = fine_q;

	// ====================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_ext_write;
		ext_live && hit_ext;
	endsequence

	// Register loads one edge after the write, output flop one edge later
	sequence s_pattern_shown;
		##2 test_pattern_enable == $past(wr_bus.wr_data[EXT_TEST_PAT], 2);
	endsequence

	a_mode_resolve: assert property ($rose(lock_q == CMFS_HELD)
		|-> ext_q == $past(ext_pick))
		else $error("resolved mode differs from strap decode");
	a_mode_frozen: assert property ((lock_q == CMFS_HELD) |=> $stable(ext_q))
		else $error("control mode changed after lock");
	a_rate_mux: assert property (ext_live |=> double_rate_select_n == $past(r_rate_n))
		else $error("extended rate not taken from register");
	a_simple_phase: assert property (!ext_live |=> !ddr_clock_phase_sel)
		else $error("simple mode phase not zero");
	a_swing_strap: assert property (!ext_live |=> output_swing_sel == $past(swing_s))
		else $error("simple swing not following strap");
	a_delay_short: assert property (ext_live |=> !cal_delay_long)
		else $error("long delay in extended mode");
	a_offset_none: assert property (!ext_live |=>
		offset_i == OFFSET_NONE && offset_q == OFFSET_NONE)
		else $error("offset applied in simple mode");
	a_ddr_float: assert property (!ext_live && rate_mid |=> !double_rate_select_n)
		else $error("floating rate strap did not give DDR");
	a_pattern_path: assert property (s_ext_write |-> s_pattern_shown)
		else $error("test pattern write not reflected");
	a_simple_quiet: assert property (!ext_live |=> !test_pattern_enable && !trim_off_clock_always
		&& second_clock_n)
		else $error("register feature active in simple mode");
	a_phase_fields: assert property (ext_live |=>
		phase_fine == $past(phase_fine_adjust_q[FIELD_MSB:FINE_LSB])
		&& phase_coarse == $past(phase_coarse_adjust_q[FIELD_MSB:FIELD_LSB]))
		else $error("phase fields not routed");

	// Simple mode: each strap-driven control trails its strap by one output flop; Q input held off
	a_edge_strap: assert property (!ext_live |=> sdr_edge_demux_sel == $past(rate_hi))
		else $error("simple edge not following strap");
	a_delay_strap: assert property (!ext_live |=> cal_delay_long == $past(delay_hi))
		else $error("simple delay not following strap");
	a_range_shared: assert property (!ext_live |=> range_i == range_q)
		else $error("simple range differs between channels");
	a_dual_strap: assert property (!ext_live |=> interleave_enable == $past(delay_mid))
		else $error("simple interleave not from delay strap");
	a_i_only: assert property (!ext_live |=> !interleave_q_input)
		else $error("Q input chosen in simple mode");

	// Extended mode: every control but the calibration delay follows its register field
	a_ext_phase: assert property (ext_live |=> ddr_clock_phase_sel == $past(r_phase))
		else $error("extended phase not taken from register");
	a_ext_swing: assert property (ext_live |=> output_swing_sel == $past(r_swing))
		else $error("extended swing not taken from register");
	a_ext_edge: assert property (ext_live |=> sdr_edge_demux_sel == $past(r_edge))
		else $error("extended edge select not taken from register");
	a_ext_range: assert property (ext_live |=>
		range_i == $past(i_channel_range_q[FIELD_MSB:FIELD_LSB])
		&& range_q == $past(q_channel_range_q[FIELD_MSB:FIELD_LSB]))
		else $error("extended range not taken from registers");
	a_ext_offset: assert property (ext_live |=>
		offset_i == $past(i_channel_offset_q[FIELD_MSB:FIELD_LSB])
		&& offset_q == $past(q_channel_offset_q[FIELD_MSB:FIELD_LSB]))
		else $error("extended offset not taken from registers");
	a_ext_dual: assert property (ext_live |=>
		interleave_enable == $past(r_des) && interleave_q_input == $past(r_des_q))
		else $error("extended interleave not taken from register");
	a_ext_trim: assert property (ext_live |=> trim_off_clock_always == $past(r_trim))
		else $error("extended trim field not routed");
	a_ext_second: assert property (ext_live |=> second_clock_n == $past(r_second_n))
		else $error("extended second clock field not routed");
	a_mode_flag: assert property (1'b1 |=> ext_mode == $past(ext_live))
		else $error("mode flag not following resolved mode");
endmodule : cmfs_top

// [tb/cmfs_host_model.sv]
// ====================================================================
// Board straps and serial register host
module cmfs_host_model
	import cmfs_pkg::*;
(
	input  wire logic        clk,
	output logic      [10:0] straps,
	output logic             sclk,
	output logic             sdata,
	output logic             scs_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus: clock parked low, chip select high
	initial
	begin
		straps = 11'h415;
		sclk = 1'b0;
		sdata = 1'b1;
		scs_n = 1'b1;
	end

	// Mode straps move only in reset, save one deliberate lock check
	task automatic set_straps(input logic [10:0] val);
		straps = val;
	endtask : set_straps

	// One 32-bit frame, MSB first; sclk high and low for 3 clocks each
	task automatic send_frame(input logic [3:0] addr, input logic [15:0] data,
		input logic [11:0] hdr, input logic hold);
		logic [31:0] word;
		word = {hdr, addr, data};
		@(posedge clk);
		#1;
		scs_n = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			sdata = word[i];
			repeat (3) @(posedge clk);
			#1;
			sclk = 1'b1;
			repeat (3) @(posedge clk);
			#1;
			sclk = 1'b0;
		end
		// Released line shows the inverse so a stale bit is never read as valid
		if (!hold)
		begin
			scs_n = 1'b1;
			sdata = ~word[0];
		end
	endtask : send_frame
endmodule : cmfs_host_model

// [tb/testbench.sv]
`define CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
		end \
	end

// ====================================================================
// Top of the bench
module testbench
	import cmfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [1:0] HI  = 2'h2;
	localparam logic [1:0] LO  = 2'h1;
	localparam logic [1:0] MID = 2'h0;

	logic        clk, rstn, sclk, sdata, scs_n;
	logic [10:0] straps;
	logic        ext_mode, double_rate_select_n, ddr_clock_phase_sel, sdr_edge_demux_sel;
	logic        output_swing_sel, cal_delay_long, interleave_enable, interleave_q_input;
	logic        test_pattern_enable, trim_off_clock_always, second_clock_n;
	logic [8:0]  range_i, range_q, offset_i, offset_q, phase_coarse;
	logic [7:0]  phase_fine;
	logic [10:0] flags;
	int          bad_count;
	int          checks;

	// Single-bit controls gathered for one compare each
	assign flags = {ext_mode, double_rate_select_n, ddr_clock_phase_sel, sdr_edge_demux_sel,
		output_swing_sel, cal_delay_long, interleave_enable, interleave_q_input,
		test_pattern_enable, trim_off_clock_always, second_clock_n};

	cmfs_host_model cmfs_host_model_inst
	(
		.clk(clk), .straps(straps), .sclk(sclk), .sdata(sdata), .scs_n(scs_n)
	);

	cmfs_top cmfs_top_inst
	(
		.clk(clk), .rstn(rstn), .mode_sel_n_hi(straps[10]), .mode_sel_n_lo(straps[9]),
		.mode_qual_hi(straps[8]), .mode_qual_lo(straps[7]),
		.range_strap_hi(straps[6]), .range_strap_lo(straps[5]),
		.rate_edge_hi(straps[4]), .rate_edge_lo(straps[3]),
		.delay_strap_hi(straps[2]), .delay_strap_lo(straps[1]), .swing_strap(straps[0]),
		.sclk(sclk), .sdata(sdata), .scs_n(scs_n), .ext_mode(ext_mode),
		.double_rate_select_n(double_rate_select_n), .ddr_clock_phase_sel(ddr_clock_phase_sel),
		.sdr_edge_demux_sel(sdr_edge_demux_sel), .output_swing_sel(output_swing_sel),
		.cal_delay_long(cal_delay_long), .range_i(range_i), .range_q(range_q),
		.offset_i(offset_i), .offset_q(offset_q), .interleave_enable(interleave_enable),
		.interleave_q_input(interleave_q_input), .test_pattern_enable(test_pattern_enable),
		.trim_off_clock_always(trim_off_clock_always), .second_clock_n(second_clock_n),
		.phase_coarse(phase_coarse), .phase_fine(phase_fine)
	);

	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// Straps change only inside reset, so the mode lock sees them settled
	task automatic do_reset(input logic [10:0] s);
		@(posedge clk);
		#1;
		rstn = 1'b0;
		cmfs_host_model_inst.set_straps(s);
		repeat (3) @(posedge clk);
		#1;
		rstn = 1'b1;
		repeat (12) @(posedge clk);
		#1;
	endtask : do_reset

	task automatic strap_step(input logic [10:0] s);
		cmfs_host_model_inst.set_straps(s);
		repeat (5) @(posedge clk);
		#1;
	endtask : strap_step

	// Frame plus sync and register latency margin
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		cmfs_host_model_inst.send_frame(a, d, HDR_PATTERN, 1'b0);
		repeat (8) @(posedge clk);
		#1;
	endtask : wr

	// Hang guard: the full sequence needs about 3000 clocks
	initial
	begin
		#400000;
		bad_count++;
		end_sim();
	end

	logic [5:0] alt [5];
	logic       alt_exp [5];
	initial
	begin
		rstn = 1'b0;
		bad_count = 0;
		checks = 0;
		// Simple mode, everything from straps
		do_reset({HI, MID, HI, HI, HI, 1'b1});
		`CHK(flags, 11'h2E1);
		`CHK(range_i, RANGE_NORMAL);
		`CHK(range_q, RANGE_NORMAL);
		`CHK({offset_i, offset_q, phase_coarse, phase_fine}, 35'h0);
		strap_step({HI, MID, LO, LO, LO, 1'b0});
		`CHK(flags, 11'h201);
		`CHK(range_q, RANGE_REDUCED);
		strap_step({HI, MID, HI, MID, MID, 1'b1});
		`CHK(double_rate_select_n, 1'b0);
		`CHK(ddr_clock_phase_sel, 1'b0);
		`CHK({interleave_enable, interleave_q_input, cal_delay_long}, 3'h4);
		// Register frames must not reach the controls in simple mode
		wr(ADDR_EXT_CFG, 16'hF000);
		wr(ADDR_I_OFFSET, 16'hFF80);
		`CHK({test_pattern_enable, trim_off_clock_always, interleave_q_input}, 3'h0);
		`CHK(offset_i, OFFSET_NONE);
		// Extended mode: power-on values, straps ignored
		do_reset({LO, HI, HI, HI, HI, 1'b1});
		`CHK(flags, 11'h441);
		`CHK({range_i, range_q}, {RANGE_NORMAL, RANGE_NORMAL});
		`CHK({offset_i, offset_q, phase_coarse, phase_fine}, 35'h0);
		// Mode pins stay put while running; only feature straps move
		strap_step({LO, HI, LO, LO, HI, 1'b0});
		`CHK(flags, 11'h441);
		`CHK({range_i, range_q}, {RANGE_NORMAL, RANGE_NORMAL});
		wr(ADDR_OUTPUT_CFG, 16'h8DFF);
		`CHK(flags, 11'h780);
		wr(ADDR_EXT_CFG, 16'hF000);
		`CHK(flags, 11'h79E);
		// Back-to-back frames with chip select held low
		cmfs_host_model_inst.send_frame(ADDR_I_OFFSET, 16'hFF80, HDR_PATTERN, 1'b1);
		wr(ADDR_Q_OFFSET, 16'h0080);
		wr(ADDR_I_RANGE, 16'hAA80);
		wr(ADDR_Q_RANGE, 16'h5500);
		wr(ADDR_PHASE_FINE, 16'hA5FF);
		wr(ADDR_PHASE_CRS, 16'hE180);
		// Reserved address and bad header are dropped
		wr(4'h4, 16'hFFFF);
		cmfs_host_model_inst.send_frame(ADDR_I_OFFSET, 16'h0000, 12'h003, 1'b0);
		repeat (8) @(posedge clk);
		#1;
		`CHK({offset_i, offset_q}, {9'h1FF, 9'h001});
		`CHK({range_i, range_q}, {9'h155, 9'h0AA});
		`CHK({phase_coarse, phase_fine}, {9'h1C3, 8'hA5});
		wr(ADDR_OUTPUT_CFG, RST_OUTPUT_CFG);
		`CHK(flags, 11'h45F);
		wr(ADDR_EXT_CFG, RST_EXT_CFG);
		`CHK(flags, 11'h441);
		// Alternate selection through qualifier and range strap; last case drives the primary pin high
		alt = '{{MID, MID, MID}, {MID, HI, MID}, {MID, LO, MID}, {MID, MID, HI}, {HI, MID, MID}};
		alt_exp = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		for (int k = 0; k < 5; k++)
		begin
			do_reset({alt[k], HI, HI, 1'b1});
			`CHK(ext_mode, alt_exp[k]);
		end
		// Mode stays locked after the settle window
		strap_step({LO, HI, MID, HI, HI, 1'b1});
		`CHK(ext_mode, 1'b0);
		end_sim();
	end
endmodule : testbench
